/* hdl/uiec_mem.sv */
`timescale 1ns/1ps
`default_nettype none
// single-port-write, registered-read byte store for the endpoint1 in fifo
module uiec_mem #(
    parameter int WIDTH = 8,
    parameter int AW    = 6
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    // write side
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    // read side
    input  wire logic             rd_en,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data_q
);

    logic [WIDTH-1:0] mem_q [0:(1<<AW)-1];

    // storage carries no reset, it is only read after being written
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    // read data from a flop, which the link output register samples again as tx_data
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data_q <= '0;
        end else if (rd_en) begin
            rd_data_q <= mem_q[rd_addr];
        end
    end

endmodule
`default_nettype wire

/* hdl/uiec_pkg.sv */
// Operation
// - index register selects endpoint register view
// - iso bit clear means bulk/interrupt mode
// - in interrupt on send, flush, stall
// - in token sends packet; freeing its slot clears ready, interrupts
// - ready without data sends zero-length packet
// - stall request answers every non-iso in token stall
// - each stall sets stall-sent flag, interrupts
// - ready returns to zero when slot frees
// - double buffering frees ready after first arm
// - flush of an empty fifo raises no interrupt
// - force toggle flips toggle after every non-iso packet
// - otherwise toggle flips only on host ack
package uiec_pkg;

    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_INT_STAT  = 8'h02;
    localparam logic [7:0] IDX_INT_MASK  = 8'h07;
    localparam logic [7:0] IDX_EP_SELECT = 8'h0e;
    localparam logic [7:0] IDX_CTL_LOW   = 8'h11;
    localparam logic [7:0] IDX_CTL_HIGH  = 8'h12;
    localparam logic [7:0] IDX_OUT_LOW   = 8'h14;
    localparam logic [7:0] IDX_OUT_HIGH  = 8'h15;
    localparam logic [7:0] IDX_EP0_COUNT = 8'h16;
    localparam logic [7:0] IDX_EP1_FIFO  = 8'h21;

    // endpoint select values
    localparam logic [3:0] SEL_EP0 = 4'h0;
    localparam logic [3:0] SEL_EP1 = 4'h1;

    // in_ctl_low fields
    localparam int LO_READY     = 0;
    localparam int LO_NOT_EMPTY = 1;
    localparam int LO_UNDERRUN  = 2;
    localparam int LO_FLUSH     = 3;
    localparam int LO_STALL_REQ = 4;
    localparam int LO_STALL_SNT = 5;
    localparam int LO_CLR_TOG   = 6;
    // in_ctl_high fields
    localparam int HI_FORCE_TOG = 3;
    localparam int HI_ISO       = 6;
    localparam int HI_DOUBLE    = 7;
    // endpoint0 control field
    localparam int E0_READY     = 1;
    // interrupt status and mask fields
    localparam int INT_EP0      = 0;
    localparam int INT_EP1_IN   = 1;
    localparam int INT_BITS     = 2;

    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // ahb-lite codes
    localparam logic [1:0] HTRANS_IDLE = 2'b00;
    localparam logic       HRESP_OKAY  = 1'b0;

    // endpoint1 in transmit states
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_SEND = 3'b010,
        TX_WAIT = 3'b100
    } uiec_tx_state_t;

    // events from the usb packet engine, one-cycle pulses
    typedef struct packed {
        logic in_token;
        logic host_ack;
        logic host_timeout;
        logic ep0_sent;
        logic ep0_setup_rx;
        logic ep0_out_rx;
        logic ep0_rx_start;
        logic ep0_rx_byte;
    } uiec_link_in_t;

    // answers to the usb packet engine
    typedef struct packed {
        logic       tx_start;
        logic       tx_data1;
        logic       tx_valid;
        logic [7:0] tx_data;
        logic       tx_end;
        logic       stall;
        logic       nak;
    } uiec_link_out_t;

endpackage

/* hdl/uiec_top.sv */
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module uiec_top #(
    parameter int FIFO_AW = 6
) (
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    sys_rst,
    // ahb-lite slave
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic                    hready,
    input  wire logic [31:0]             hwdata,
    output logic      [31:0]             hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    // usb packet engine
    input  wire uiec_pkg::uiec_link_in_t link_in,
    output uiec_pkg::uiec_link_out_t     link_out,
    // interrupt
    output logic                         irq
);

    localparam int DEPTH = 1 << FIFO_AW;
    localparam int LW    = FIFO_AW + 1;

    function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
        hit = (idx == want);
    endfunction

    localparam int INT_BITS_W = uiec_pkg::INT_BITS;

    // bus state
    logic                     pend_q, pend_wr_q, hreadyout_q, wr_stb, rd_stb;
    logic [7:0]               pend_idx_q, wdat;
    logic [31:0]              hrdata_q;
    // registers
    logic [3:0]               sel_q;
    logic                     stall_req_q, stall_snt_q, underrun_q, force_tog_q, iso_q, double_q;
    logic [7:0]               out_low_q, out_high_q;
    logic                     ep0_ready_q, irq_q;
    logic [6:0]               ep0_count_q;
    logic [INT_BITS_W-1:0]    int_stat_q, int_mask_q;
    // fifo bookkeeping
    logic [FIFO_AW-1:0]       wr_ptr_q, base_q, rd_ptr_q;
    logic [LW-1:0]            cur_len_q, fill_q, remain_q;
    logic [LW-1:0]            len_q [0:1];
    logic                     head_q, ready_q, data1_q, mem_rd, mem_rd_q;
    logic [1:0]               slots_q, slots_d, cap;
    logic [7:0]               mem_data;
    uiec_pkg::uiec_tx_state_t state_q;
    uiec_pkg::uiec_link_out_t lo_q;
    // decoded actions
    logic                     sel_ep1, wr_lo, fifo_wr, commit, flush, pop, start_pkt, ep1_int, ep0_int;

    // bus address phase is taken when the slave is selected and ready
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_q      <= 1'b0;
            pend_wr_q   <= 1'b0;
            pend_idx_q  <= uiec_pkg::RST_BYTE;
            hreadyout_q <= 1'b1;
        end else if (hsel && htrans[1] && hready) begin
            pend_q      <= 1'b1;
            pend_wr_q   <= hwrite;
            pend_idx_q  <= haddr[9:2];
            hreadyout_q <= 1'b0;
        end else begin
            pend_q      <= 1'b0;
            hreadyout_q <= 1'b1;
        end
    end

    // one wait state: data phase work is done while hreadyout is low
    assign wr_stb  = pend_q && pend_wr_q;
    assign rd_stb  = pend_q && !pend_wr_q;
    assign wdat    = hwdata[7:0];
    assign sel_ep1 = (sel_q == uiec_pkg::SEL_EP1);
    assign wr_lo   = wr_stb && hit(pend_idx_q, uiec_pkg::IDX_CTL_LOW) && sel_ep1;
    assign fifo_wr = wr_stb && hit(pend_idx_q, uiec_pkg::IDX_EP1_FIFO) && (fill_q < LW'(DEPTH));
    assign cap     = double_q ? 2'd2 : 2'd1;
    assign commit  = wr_lo && wdat[uiec_pkg::LO_READY] && (slots_q < cap);
    assign flush   = wr_lo && wdat[uiec_pkg::LO_FLUSH];

    // read mux, registered so hrdata comes from a flop
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata_q <= uiec_pkg::RST_WORD;
        end else if (rd_stb) begin
            hrdata_q <= uiec_pkg::RST_WORD;
            case (1'b1)
                hit(pend_idx_q, uiec_pkg::IDX_EP_SELECT): hrdata_q[3:0] <= sel_q;
                hit(pend_idx_q, uiec_pkg::IDX_INT_STAT):  hrdata_q[INT_BITS_W-1:0] <= int_stat_q;
                hit(pend_idx_q, uiec_pkg::IDX_INT_MASK):  hrdata_q[INT_BITS_W-1:0] <= int_mask_q;
                hit(pend_idx_q, uiec_pkg::IDX_EP0_COUNT): hrdata_q[6:0] <= ep0_count_q;
                hit(pend_idx_q, uiec_pkg::IDX_CTL_LOW): begin
                    if (sel_ep1) begin
                        hrdata_q[uiec_pkg::LO_READY]     <= ready_q;
                        hrdata_q[uiec_pkg::LO_NOT_EMPTY] <= (slots_q != 2'd0);
                        hrdata_q[uiec_pkg::LO_UNDERRUN]  <= underrun_q;
                        hrdata_q[uiec_pkg::LO_STALL_REQ] <= stall_req_q;
                        hrdata_q[uiec_pkg::LO_STALL_SNT] <= stall_snt_q;
                    end else begin
                        hrdata_q[uiec_pkg::E0_READY] <= ep0_ready_q;
                    end
                end
                hit(pend_idx_q, uiec_pkg::IDX_CTL_HIGH): begin
                    if (sel_ep1) begin
                        hrdata_q[uiec_pkg::HI_FORCE_TOG] <= force_tog_q;
                        hrdata_q[uiec_pkg::HI_ISO]       <= iso_q;
                        hrdata_q[uiec_pkg::HI_DOUBLE]    <= double_q;
                    end
                end
                hit(pend_idx_q, uiec_pkg::IDX_OUT_LOW):  hrdata_q[7:0] <= sel_ep1 ? out_low_q : uiec_pkg::RST_BYTE;
                hit(pend_idx_q, uiec_pkg::IDX_OUT_HIGH): hrdata_q[7:0] <= sel_ep1 ? out_high_q : uiec_pkg::RST_BYTE;
                default: hrdata_q <= uiec_pkg::RST_WORD; // unmapped reads as zero
            endcase
        end
    end

    // plain configuration registers written by software
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_q       <= uiec_pkg::SEL_EP0;
            stall_req_q <= 1'b0;
            force_tog_q <= 1'b0;
            iso_q       <= 1'b0;
            double_q    <= 1'b0;
            out_low_q   <= uiec_pkg::RST_BYTE;
            out_high_q  <= uiec_pkg::RST_BYTE;
            int_mask_q  <= '0;
        end else if (wr_stb) begin
            if (hit(pend_idx_q, uiec_pkg::IDX_EP_SELECT)) begin
                sel_q <= wdat[3:0];
            end
            if (hit(pend_idx_q, uiec_pkg::IDX_INT_MASK)) begin
                int_mask_q <= wdat[INT_BITS_W-1:0];
            end
            if (wr_lo) begin
                stall_req_q <= wdat[uiec_pkg::LO_STALL_REQ];
            end
            if (sel_ep1 && hit(pend_idx_q, uiec_pkg::IDX_CTL_HIGH)) begin
                force_tog_q <= wdat[uiec_pkg::HI_FORCE_TOG];
                iso_q       <= wdat[uiec_pkg::HI_ISO];
                double_q    <= wdat[uiec_pkg::HI_DOUBLE];
            end
            if (sel_ep1 && hit(pend_idx_q, uiec_pkg::IDX_OUT_LOW)) begin
                out_low_q <= wdat;
            end
            if (sel_ep1 && hit(pend_idx_q, uiec_pkg::IDX_OUT_HIGH)) begin
                out_high_q <= wdat;
            end
        end
    end

    // a token is served only from idle; tokens during a transfer are dropped
    assign start_pkt = (state_q == uiec_pkg::TX_IDLE) && link_in.in_token;
    // slot freed on ack, or at end of an iso packet which expects no handshake
    assign pop = !flush && (((state_q == uiec_pkg::TX_WAIT) && link_in.host_ack)
              || ((state_q == uiec_pkg::TX_SEND) && iso_q && (remain_q == '0) && !mem_rd_q));
    assign mem_rd = (state_q == uiec_pkg::TX_SEND) && (remain_q != '0);

    // packet slots: ready reads high only while no slot is open
    always_comb begin
        slots_d = slots_q;
        if (flush) begin
            slots_d = 2'd0;
        end else begin
            slots_d = slots_q + {1'b0, commit} - {1'b0, pop};
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            slots_q   <= 2'd0;
            ready_q   <= 1'b0;
            head_q    <= 1'b0;
            base_q    <= '0;
            wr_ptr_q  <= '0;
            cur_len_q <= '0;
            fill_q    <= '0;
            len_q[0]  <= '0;
            len_q[1]  <= '0;
        end else begin
            slots_q <= slots_d;
            ready_q <= (slots_d >= cap);
            if (flush) begin
                head_q    <= 1'b0;
                base_q    <= '0;
                wr_ptr_q  <= '0;
                cur_len_q <= '0;
                fill_q    <= '0;
            end else begin
                if (fifo_wr) begin
                    wr_ptr_q <= wr_ptr_q + 1'b1;
                end
                if (commit) begin
                    // an empty commit stores length zero for a zero-length packet
                    len_q[head_q ^ slots_q[0]] <= cur_len_q;
                    cur_len_q <= LW'(fifo_wr);
                end else if (fifo_wr) begin
                    cur_len_q <= cur_len_q + 1'b1;
                end
                if (pop) begin
                    head_q <= !head_q;
                    base_q <= base_q + len_q[head_q][FIFO_AW-1:0];
                end
                fill_q <= fill_q + LW'(fifo_wr) - (pop ? len_q[head_q] : '0);
            end
        end
    end

    // transmit sequencer
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q  <= uiec_pkg::TX_IDLE;
            remain_q <= '0;
            rd_ptr_q <= '0;
            mem_rd_q <= 1'b0;
            lo_q     <= '0;
        end else begin
            mem_rd_q       <= mem_rd;
            lo_q.tx_start  <= 1'b0;
            lo_q.tx_end    <= 1'b0;
            lo_q.stall     <= 1'b0;
            lo_q.nak       <= 1'b0;
            lo_q.tx_valid  <= mem_rd_q;
            lo_q.tx_data   <= mem_data;
            lo_q.tx_data1  <= data1_q;
            case (state_q)
                uiec_pkg::TX_IDLE: begin
                    if (start_pkt) begin
                        if (stall_req_q && !iso_q) begin
                            lo_q.stall <= 1'b1;
                        end else if (slots_q != 2'd0) begin
                            lo_q.tx_start <= 1'b1;
                            remain_q      <= len_q[head_q];
                            rd_ptr_q      <= base_q;
                            state_q       <= uiec_pkg::TX_SEND;
                        end else if (iso_q) begin
                            lo_q.tx_start <= 1'b1; // empty iso: zero-length packet
                            remain_q      <= '0;
                            state_q       <= uiec_pkg::TX_SEND;
                        end else begin
                            lo_q.nak <= 1'b1;
                        end
                    end
                end
                uiec_pkg::TX_SEND: begin
                    if (flush) begin
                        state_q <= uiec_pkg::TX_IDLE;
                    end else if (remain_q != '0) begin
                        remain_q <= remain_q - 1'b1;
                        rd_ptr_q <= rd_ptr_q + 1'b1;
                    end else if (!mem_rd_q) begin
                        lo_q.tx_end <= 1'b1;
                        state_q     <= iso_q ? uiec_pkg::TX_IDLE : uiec_pkg::TX_WAIT;
                    end
                end
                uiec_pkg::TX_WAIT: begin
                    // a timeout leaves the packet queued for the host to retry
                    if (flush || link_in.host_ack || link_in.host_timeout) begin
                        state_q <= uiec_pkg::TX_IDLE;
                    end
                end
                default: state_q <= uiec_pkg::TX_IDLE;
            endcase
        end
    end

    // data toggle
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            data1_q <= 1'b0;
        end else if (wr_lo && wdat[uiec_pkg::LO_CLR_TOG]) begin
            data1_q <= 1'b0;
        end else if (state_q == uiec_pkg::TX_WAIT) begin
            if (link_in.host_ack || (force_tog_q && link_in.host_timeout)) begin
                data1_q <= !data1_q;
            end
        end
    end

    // stall-sent and underrun: hardware set wins over a software write
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stall_snt_q <= 1'b0;
            underrun_q  <= 1'b0;
        end else begin
            if (start_pkt && stall_req_q && !iso_q) begin
                stall_snt_q <= 1'b1;
            end else if (wr_lo && !wdat[uiec_pkg::LO_STALL_SNT]) begin
                stall_snt_q <= 1'b0;
            end
            if (start_pkt && (slots_q == 2'd0) && !(stall_req_q && !iso_q)) begin
                underrun_q <= 1'b1;
            end else if (wr_lo && !wdat[uiec_pkg::LO_UNDERRUN]) begin
                underrun_q <= 1'b0;
            end
        end
    end

    // endpoint0 ready and received byte count
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ep0_ready_q <= 1'b0;
            ep0_count_q <= '0;
        end else begin
            if (ep0_int) begin
                ep0_ready_q <= 1'b0;
            end else if (wr_stb && hit(pend_idx_q, uiec_pkg::IDX_CTL_LOW) && !sel_ep1
                         && wdat[uiec_pkg::E0_READY]) begin
                ep0_ready_q <= 1'b1;
            end
            if (link_in.ep0_rx_start) begin
                ep0_count_q <= '0;
            end else if (link_in.ep0_rx_byte && (ep0_count_q != '1)) begin
                ep0_count_q <= ep0_count_q + 1'b1;
            end
        end
    end

    // only a sent packet freeing its slot, a non-empty flush or a stall interrupts, never an empty flush
    assign ep1_int = pop || (start_pkt && stall_req_q && !iso_q)
                  || (flush && (fill_q != '0 || cur_len_q != '0 || slots_q != 2'd0));
    assign ep0_int = ep0_ready_q && (link_in.ep0_sent || link_in.ep0_setup_rx || link_in.ep0_out_rx);

    // sticky status, cleared by reading it; a new event in that cycle survives
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            int_stat_q <= '0;
            irq_q      <= 1'b0;
        end else begin
            int_stat_q[uiec_pkg::INT_EP1_IN] <= ep1_int
                || (int_stat_q[uiec_pkg::INT_EP1_IN] && !(rd_stb && hit(pend_idx_q, uiec_pkg::IDX_INT_STAT)));
            int_stat_q[uiec_pkg::INT_EP0] <= ep0_int
                || (int_stat_q[uiec_pkg::INT_EP0] && !(rd_stb && hit(pend_idx_q, uiec_pkg::IDX_INT_STAT)));
            irq_q <= |(int_stat_q & int_mask_q);
        end
    end

    uiec_mem #(
        .WIDTH (8),
        .AW    (FIFO_AW)
    ) u_mem (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .wr_en     (fifo_wr),
        .wr_addr   (wr_ptr_q),
        .wr_data   (wdat),
        .rd_en     (mem_rd),
        .rd_addr   (rd_ptr_q),
        .rd_data_q (mem_data)
    );

    // outputs straight from flops, hresp tied to okay
    assign hrdata    = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp     = uiec_pkg::HRESP_OKAY;
    assign link_out  = lo_q;
    assign irq       = irq_q;

endmodule
`default_nettype wire

/* tb/test_usb_in_endpoint_control.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) \
    begin comparisons++; if ((a) !== (e)) begin failures++; \
    $display("unexpected %s exp %0h got %0h", n, e, a); end end
module test_usb_in_endpoint_control;
    logic                     ref_clk = 1'b0;
    logic                     sys_rst = 1'b1;
    logic [31:0]              haddr = '0, hwdata = '0, hrdata, d;
    logic [1:0]               htrans = '0;
    logic                     hwrite = 1'b0, hreadyout, hresp, irq, tog;
    logic [2:0]               hs;
    logic [4:0]               ev = '0;
    uiec_pkg::uiec_link_in_t  link_in;
    uiec_pkg::uiec_link_out_t link_out;
    int                       failures = 0, comparisons = 0, kind;
    assign link_in = {hs, ev};
    always #5 ref_clk = ~ref_clk;
    uiec_top DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .link_in(link_in), .link_out(link_out), .irq(irq));
    uiec_host_model host (.ref_clk(ref_clk), .link_out(link_out), .hs(hs));
    // one single word transfer, address held until hready
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        haddr <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask
    task automatic rd(input string n, input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e);
        bus(1'b0, idx, '0);
        `CHK(n, e, d[7:0] & m)
        `CHK("hresp", 1'b0, hresp)
    endtask
    task automatic pulse(input logic [4:0] v);
        ev <= v;
        @(posedge ref_clk);
        ev <= 5'h00;
        @(posedge ref_clk);
    endtask
    task automatic t_bulk;
        for (int i = 0; i < 3; i++) bus(1'b1, uiec_pkg::IDX_EP1_FIFO, 32'h0000_00a0 + i);
        bus(1'b1, uiec_pkg::IDX_CTL_LOW, 32'h0000_0001);
        rd("armed", uiec_pkg::IDX_CTL_LOW, 8'h03, 8'h03);
        `CHK("irq", 1'b0, irq)
        host.in_xfer(1'b1, 0, kind, tog);
        `CHK("kind", 1, kind)
        `CHK("tog", 1'b0, tog)
        `CHK("len", 3, host.rx_q.size())
        `CHK("byte", 8'ha2, host.rx_q[2])
        repeat (2) @(posedge ref_clk);
        `CHK("irq", 1'b1, irq)
        rd("ready", uiec_pkg::IDX_CTL_LOW, 8'h01, 8'h00);
        rd("stat", uiec_pkg::IDX_INT_STAT, 8'h02, 8'h02);
        rd("clr", uiec_pkg::IDX_INT_STAT, 8'h02, 8'h00);
    endtask
    // forced toggle flips on a mute host, plain toggle does not
    task automatic t_toggle;
        bus(1'b1, uiec_pkg::IDX_CTL_HIGH, 32'h0000_0008);
        bus(1'b1, uiec_pkg::IDX_CTL_LOW, 32'h0000_0001);
        host.in_xfer(1'b0, 3, kind, tog);
        `CHK("zlen", 0, host.rx_q.size())
        `CHK("tog", 1'b1, tog)
        host.in_xfer(1'b1, 0, kind, tog);
        `CHK("ftog", 1'b0, tog)
        bus(1'b1, uiec_pkg::IDX_CTL_HIGH, 32'h0000_0000);
        bus(1'b1, uiec_pkg::IDX_CTL_LOW, 32'h0000_0001);
        host.in_xfer(1'b0, 0, kind, tog);
        `CHK("tog", 1'b1, tog)
        host.in_xfer(1'b1, 0, kind, tog);
        `CHK("tog", 1'b1, tog)
        rd("stat", uiec_pkg::IDX_INT_STAT, 8'h02, 8'h02);
    endtask
    task automatic t_stall;
        host.in_xfer(1'b1, 0, kind, tog);
        `CHK("nak", 3, kind)
        rd("under", uiec_pkg::IDX_CTL_LOW, 8'h04, 8'h04);
        bus(1'b1, uiec_pkg::IDX_CTL_LOW, 32'h0000_0010);
        for (int i = 0; i < 2; i++) begin
            host.in_xfer(1'b1, 0, kind, tog);
            `CHK("stall", 2, kind)
        end
        rd("sent", uiec_pkg::IDX_CTL_LOW, 8'h20, 8'h20);
        `CHK("irq", 1'b1, irq)
        rd("stat", uiec_pkg::IDX_INT_STAT, 8'h02, 8'h02);
        bus(1'b1, uiec_pkg::IDX_CTL_LOW, 32'h0000_0000);
        rd("sent", uiec_pkg::IDX_CTL_LOW, 8'h20, 8'h00);
    endtask
    task automatic t_double;
        bus(1'b1, uiec_pkg::IDX_CTL_HIGH, 32'h0000_0080);
        bus(1'b1, uiec_pkg::IDX_EP1_FIFO, 32'h0000_0055);
        bus(1'b1, uiec_pkg::IDX_CTL_LOW, 32'h0000_0001);
        rd("dbl", uiec_pkg::IDX_CTL_LOW, 8'h03, 8'h02);
        `CHK("irq", 1'b0, irq)
        rd("high", uiec_pkg::IDX_CTL_HIGH, 8'hff, 8'h80);
        bus(1'b1, uiec_pkg::IDX_CTL_LOW, 32'h0000_0008);
        repeat (2) @(posedge ref_clk);
        `CHK("irq", 1'b1, irq)
        rd("stat", uiec_pkg::IDX_INT_STAT, 8'h02, 8'h02);
        rd("empty", uiec_pkg::IDX_CTL_LOW, 8'h02, 8'h00);
    endtask
    // ep0 events run with their interrupt masked
    task automatic t_ep0;
        bus(1'b1, uiec_pkg::IDX_EP_SELECT, 32'h0000_0000);
        bus(1'b1, uiec_pkg::IDX_INT_MASK, 32'h0000_0002);
        rd("high", uiec_pkg::IDX_CTL_HIGH, 8'hff, 8'h00);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, uiec_pkg::IDX_CTL_LOW, 32'h0000_0002);
            pulse(5'h10 >> i);
            rd("e0rdy", uiec_pkg::IDX_CTL_LOW, 8'h02, 8'h00);
            `CHK("irq", 1'b0, irq)
            rd("e0int", uiec_pkg::IDX_INT_STAT, 8'h01, 8'h01);
        end
        pulse(5'h02);
        repeat (5) pulse(5'h01);
        rd("count", uiec_pkg::IDX_EP0_COUNT, 8'hff, 8'h05);
        rd("hole", 8'h30, 8'hff, 8'h00);
    endtask
    task automatic results;
        if (failures == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        rd("stat0", uiec_pkg::IDX_INT_STAT, 8'hff, 8'h00);
        bus(1'b1, uiec_pkg::IDX_EP_SELECT, 32'h0000_0001);
        bus(1'b1, uiec_pkg::IDX_INT_MASK, 32'h0000_0003);
        t_bulk();
        t_toggle();
        t_stall();
        t_double();
        t_ep0();
        results();
    end
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        results();
    end
endmodule
`default_nettype wire

/* tb/uiec_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module uiec_assertions (
    // clock and reset
    input wire logic                     ref_clk,
    input wire logic                     sys_rst,
    // bus handshake
    input wire logic                     hsel,
    input wire logic [1:0]               htrans,
    input wire logic                     hready,
    input wire logic                     hreadyout,
    // packet engine
    input wire uiec_pkg::uiec_link_in_t  link_in,
    input wire uiec_pkg::uiec_link_out_t link_out
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // every accepted transfer costs exactly one wait state
    a_bus_wait: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
        else $error("bus wait state wrong");
    // an answer only ever follows a token by one cycle
    a_answer_cause: assert property (link_out.stall || link_out.nak || link_out.tx_start |-> $past(link_in.in_token))
        else $error("answer without token");
    a_stall_alone: assert property (link_out.stall |-> !link_out.nak && !link_out.tx_start)
        else $error("stall mixed with other answer");
    a_data_follows: assert property (link_out.tx_start |=> (link_out.tx_end or ##1 link_out.tx_valid))
        else $error("no data or end after start");
    a_end_cause: assert property (link_out.tx_end |-> $past(link_out.tx_valid) || $past(link_out.tx_start))
        else $error("end out of place");
    a_valid_run: assert property (link_out.tx_valid ##1 !link_out.tx_valid |-> link_out.tx_end)
        else $error("bytes not closed by end");
    // tokens during a send are ignored, so no restart
    a_start_single: assert property (link_out.tx_start |=> !link_out.tx_start [*3])
        else $error("restart during send");
    a_toggle_steady: assert property (link_out.tx_valid |-> $stable(link_out.tx_data1))
        else $error("toggle moved mid packet");
endmodule
bind uiec_top uiec_assertions u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .htrans(htrans),
    .hready(hready), .hreadyout(hreadyout), .link_in(link_in), .link_out(link_out));
`default_nettype wire

/* tb/uiec_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// usb host stand-in: token, collect packet, then handshake or stay mute
module uiec_host_model (
    // clock
    input wire logic                     ref_clk,
    // packet engine view
    input wire uiec_pkg::uiec_link_out_t link_out,
    output logic [2:0]                   hs
);
    logic [7:0] rx_q[$];
    initial hs = 3'h0;
    // kind 1 data, 2 stall, 3 nak; slow delays the handshake
    task automatic in_xfer(input logic ack, input int slow, output int kind, output logic tog);
        kind = 0;
        tog = 1'b0;
        rx_q = {};
        hs <= 3'h4;
        @(posedge ref_clk);
        hs <= 3'h0;
        #1;
        if (link_out.stall) kind = 2;
        if (link_out.nak) kind = 3;
        if (link_out.tx_start) begin
            kind = 1;
            tog = link_out.tx_data1;
            for (int t = 0; t < 100 && !link_out.tx_end; t++) begin
                @(posedge ref_clk);
                #1;
                if (link_out.tx_valid) rx_q.push_back(link_out.tx_data);
            end
            repeat (slow) @(posedge ref_clk);
            hs <= ack ? 3'h2 : 3'h1;
            @(posedge ref_clk);
            hs <= 3'h0;
        end
        @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire
